// file: common/bod_pkg.sv
// package for the byte-op decoder: opcode fields, flag layout, constants
// assumes one instruction clock; data memory sits in logic/bod_data_mem.sv
package bod_pkg;

    // instruction field widths and positions
    localparam int W_INSN          = 16;
    localparam int W_BYTE          = 8;
    localparam int W_PC            = 21;
    localparam int W_LIT           = 20;
    localparam int W_BANK          = 4;
    localparam int W_ADDR          = 12;
    localparam int BANK_BIT_POS    = 8;

    // opcode patterns
    localparam logic [6:0]  OPC_NEGATE     = 7'h36;  // 0110 110
    localparam logic [7:0]  OPC_BRANCH_W1  = 8'hEF;  // 1110 1111
    localparam logic [3:0]  OPC_BRANCH_W2  = 4'hF;   // 1111 upper nibble
    localparam logic [15:0] OPC_ZERO_WORD  = 16'h0000;

    // indexed literal-offset boundary
    localparam logic [7:0]  IDX_LIMIT      = 8'h5F;
    // access bank upper part, from 0x60 up, lives in bank 15
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;

    // reset values
    localparam logic [W_PC-1:0]   PC_RESET   = 21'h000000;
    localparam logic [W_BANK-1:0] BANK_RESET = 4'h0;

    // status flag positions
    localparam int FLG_C  = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N  = 4;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } bod_flags_t;

    typedef struct packed {
        logic              we;
        logic [W_ADDR-1:0] addr;
        logic [W_BYTE-1:0] wdata;
    } bod_mem_wr_t;

    typedef enum logic [1:0] {
        ST_EXEC   = 2'b00,
        ST_FETCH2 = 2'b01,
        ST_FLUSH  = 2'b10
    } bod_state_t;

endpackage : bod_pkg

// file: logic/bod_data_mem.sv
// data memory for the decoder: 4096 bytes, registered read data
// assumes synchronous write and one-cycle read latency
`timescale 1ns/10ps
`default_nettype none
module bod_data_mem (
    // clock
    input  wire logic                       i_clk,
    // read port
    input  wire logic [bod_pkg::W_ADDR-1:0] i_raddr,
    output logic      [bod_pkg::W_BYTE-1:0] o_rdata,
    // write port
    input  wire bod_pkg::bod_mem_wr_t       i_wr
);
    import bod_pkg::*;

    logic [W_BYTE-1:0] mem_reg [0:(1<<W_ADDR)-1];

    // write port
    always_ff @(posedge i_clk) begin
        if (i_wr.we) begin
            mem_reg[i_wr.addr] <= i_wr.wdata;
        end
    end

    // registered read
    always_ff @(posedge i_clk) begin
        o_rdata <= mem_reg[i_raddr];
    end
endmodule : bod_data_mem
`default_nettype wire

// file: logic/bod_decoder.sv
// byte-op decoder: bank selection, indexed addressing, negate, no-op, long branch
// assumes a valid instruction word each cycle when i_insn_valid is high
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - bank bit clear uses access bank; set uses bank select register.
// - bank bit clear, extended set on, operand <= 95: indexed literal offset.
// - negate forms two's complement, writes back, updates N OV C DC Z.
// - all-zero word or upper nibble all ones is a no-op.
module bod_decoder (
    // clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_rstn,
    // instruction stream
    input  wire logic                        i_insn_valid,
    input  wire logic [bod_pkg::W_INSN-1:0]  i_insn,
    output logic                             o_insn_ready,
    // configuration
    input  wire logic                        i_ext_set_en,
    input  wire logic [bod_pkg::W_BANK-1:0]  i_bank_select_register,
    input  wire logic                        i_bank_select_load,
    input  wire logic [bod_pkg::W_ADDR-1:0]  i_index_base,
    // results
    output logic      [bod_pkg::W_PC-1:0]    o_pc,
    output bod_pkg::bod_flags_t              o_flags,
    output logic      [bod_pkg::W_ADDR-1:0]  o_eff_addr,
    output logic                             o_busy
);
    import bod_pkg::*;

    function automatic logic [W_ADDR-1:0] eff_addr(
        input logic [W_INSN-1:0] insn,
        input logic              ext_en,
        input logic [W_BANK-1:0] bank,
        input logic [W_ADDR-1:0] base
    );
        logic [7:0] f;
        f = insn[7:0];
        if (!insn[BANK_BIT_POS] && ext_en && f <= IDX_LIMIT) begin
            eff_addr = base + {4'h0, f};
        end else if (!insn[BANK_BIT_POS]) begin
            eff_addr = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HI_BANK, f};
        end else begin
            eff_addr = {bank, f};
        end
    endfunction : eff_addr

    bod_state_t        state_reg;
    logic [W_BANK-1:0] bank_reg;
    logic [W_PC-1:0]   pc_reg;
    bod_flags_t        flags_reg;
    logic [7:0]        lit_lo_reg;
    logic [W_ADDR-1:0] neg_addr_reg;
    logic              neg_pend_reg;
    logic [W_ADDR-1:0] addr_now;
    logic [W_BYTE-1:0] rdata;
    logic [W_BYTE-1:0] neg_res;
    bod_mem_wr_t       wr;
    logic              take;
    logic              is_neg;
    logic              is_br;
    logic              is_nop;

    assign take     = i_insn_valid && o_insn_ready;
    assign is_neg   = i_insn[15:9] == OPC_NEGATE;
    assign is_br    = i_insn[15:8] == OPC_BRANCH_W1;
    assign is_nop   = (i_insn == OPC_ZERO_WORD) || (i_insn[15:12] == OPC_BRANCH_W2);
    assign addr_now = eff_addr(i_insn, i_ext_set_en, bank_reg, i_index_base);
    assign o_insn_ready = (state_reg != ST_FLUSH) && !neg_pend_reg;
    assign o_busy   = (state_reg != ST_EXEC) || neg_pend_reg;
    assign o_pc     = pc_reg;
    assign o_flags  = flags_reg;

    // bank select register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bank_reg <= BANK_RESET;
        end else if (i_bank_select_load) begin
            bank_reg <= i_bank_select_register;
        end
    end

    // effective address of last byte op
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_eff_addr <= '0;
        end else if (take && state_reg == ST_EXEC && is_neg) begin
            o_eff_addr <= addr_now;
        end
    end

    // negate capture; read then write back
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            neg_pend_reg <= 1'b0;
            neg_addr_reg <= '0;
        end else begin
            neg_pend_reg <= take && state_reg == ST_EXEC && is_neg;
            if (take && state_reg == ST_EXEC && is_neg) begin
                neg_addr_reg <= addr_now;
            end
        end
    end

    assign neg_res  = W_BYTE'(~rdata + 8'h01);
    assign wr.we    = neg_pend_reg;
    assign wr.addr  = neg_addr_reg;
    assign wr.wdata = neg_res;

    bod_data_mem bod_data_mem_i (
        .i_clk   (i_clk),
        .i_raddr (addr_now),
        .o_rdata (rdata),
        .i_wr    (wr)
    );

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_reg <= '0;
        end else if (neg_pend_reg) begin
            flags_reg.n  <= neg_res[7];
            flags_reg.z  <= neg_res == 8'h00;
            flags_reg.ov <= rdata == 8'h80;
            flags_reg.c  <= rdata == 8'h00;
            flags_reg.dc <= rdata[3:0] == 4'h0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg  <= ST_EXEC;
            lit_lo_reg <= 8'h00;
        end else begin
            case (state_reg)
                ST_EXEC: begin
                    if (take && is_br) begin
                        lit_lo_reg <= i_insn[7:0];
                        state_reg  <= ST_FETCH2;
                    end
                end
                ST_FETCH2: begin
                    if (take) begin
                        state_reg <= ST_FLUSH;
                    end
                end
                ST_FLUSH: begin
                    state_reg <= ST_EXEC;
                end
                default: begin
                    state_reg <= ST_EXEC;
                end
            endcase
        end
    end

    // program counter
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_reg <= PC_RESET;
        end else if (take && state_reg == ST_FETCH2) begin
            pc_reg <= {i_insn[11:0], lit_lo_reg, 1'b0};
        end else if (take && state_reg == ST_EXEC && (is_nop || !is_br)) begin
            pc_reg <= W_PC'(pc_reg + 21'h000002);
        end
    end
endmodule : bod_decoder
`default_nettype wire

// file: test/bod_decoder_asserts.sv
// port checker for bod_decoder
// assumes one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module bod_decoder_asserts
    import bod_pkg::*;
(
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rstn,
    // instruction stream
    input wire logic        i_insn_valid,
    input wire logic [15:0] i_insn,
    input wire logic        o_insn_ready,
    // configuration
    input wire logic        i_ext_set_en,
    input wire logic [3:0]  i_bank_select_register,
    input wire logic        i_bank_select_load,
    input wire logic [11:0] i_index_base,
    // results
    input wire logic [20:0] o_pc,
    input wire bod_flags_t  o_flags,
    input wire logic [11:0] o_eff_addr,
    input wire logic        o_busy
);
    logic [3:0] bank_reg;
    logic       take, neg, w1, idx;
    assign take = i_insn_valid && o_insn_ready && !o_busy;
    assign neg  = take && i_insn[15:9] == OPC_NEGATE;
    assign w1   = take && i_insn[15:8] == OPC_BRANCH_W1;
    assign idx  = i_ext_set_en && i_insn[7:0] <= IDX_LIMIT;
    // shadow of the bank select value
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) bank_reg <= BANK_RESET;
        else if (i_bank_select_load) bank_reg <= i_bank_select_register;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_negate_stall: assert property (neg |=> o_busy && !o_insn_ready)
        else $error("negate did not stall for write-back");
    a_bank_select: assert property (neg && i_insn[8] |-> ##2
        o_eff_addr == {$past(bank_reg, 2), $past(i_insn[7:0], 2)})
        else $error("banked address wrong");
    a_access_bank: assert property (neg && !i_insn[8] && !idx |-> ##2
        o_eff_addr == {($past(i_insn[7:0], 2) < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK,
        $past(i_insn[7:0], 2)})
        else $error("access bank address wrong");
    a_indexed_addr: assert property (neg && !i_insn[8] && idx |-> ##2
        o_eff_addr == $past(i_index_base, 2) + {4'h0, $past(i_insn[7:0], 2)})
        else $error("indexed address wrong");
    a_nop_quiet: assert property (take && (i_insn == OPC_ZERO_WORD ||
        i_insn[15:12] == 4'hF) |=> o_pc == $past(o_pc) + 21'h2 && $stable(o_flags))
        else $error("no-op changed state");
    a_branch_wait: assert property (w1 |=> o_busy)
        else $error("branch first word not followed by busy");
    a_branch_pc: assert property (w1 ##1 i_insn_valid && o_insn_ready |=>
        o_pc == {$past(i_insn[11:0]), $past(i_insn[7:0], 2), 1'b0})
        else $error("branch target wrong");
    a_branch_flush: assert property (w1 ##1 i_insn_valid && o_insn_ready |=>
        !o_insn_ready && o_busy ##1 o_insn_ready)
        else $error("branch flush cycle wrong");
    c_negate: cover property (neg);
    c_indexed: cover property (neg && idx);
    c_branch: cover property (w1 ##1 i_insn_valid && o_insn_ready);
endmodule : bod_decoder_asserts
bind bod_decoder bod_decoder_asserts bod_decoder_asserts_i (.*);
`default_nettype wire

// file: test/bod_decoder_tb.sv
// testbench for bod_decoder: no-op, negate addressing, long branch
// assumes the port checker is bound from its own file
`timescale 1ns/10ps
`default_nettype none
module bod_decoder_tb;
    import bod_pkg::*;
    logic        clk = 0, rstn = 0, valid = 0, ext = 0, bload = 0;
    logic [15:0] insn = 16'h0000;
    logic [3:0]  bank_select_register = 4'h0;
    logic [11:0] base = 12'h000, eff;
    logic [20:0] pc, p;
    logic        ready, busy;
    bod_flags_t  flags;
    int          failures = 0, num_checks = 0;
    always #5 clk = ~clk;
    bod_decoder bod_decoder_i (.i_clk(clk), .i_rstn(rstn), .i_insn_valid(valid),
        .i_insn(insn), .o_insn_ready(ready), .i_ext_set_en(ext),
        .i_bank_select_register(bank_select_register), .i_bank_select_load(bload), .i_index_base(base),
        .o_pc(pc), .o_flags(flags), .o_eff_addr(eff), .o_busy(busy));
    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done;
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    // wait for ready, present a word, return after the take edge
    task automatic issue(input logic [15:0] w);
        for (int n = 0; n < 20 && ready !== 1'b1; n++) @(negedge clk);
        if (ready !== 1'b1) failures++;
        insn = w;
        valid = 1'b1;
        @(negedge clk);
    endtask : issue
    task automatic idle(input int n);
        valid = 1'b0;
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic neg(input logic a, input logic [7:0] f, input logic [11:0] exp);
        issue({OPC_NEGATE, a, f});
        chk("busy", 21'h1, 21'(busy));
        chk("ready", 21'h0, 21'(ready));
        idle(2);
        chk("eff_addr", 21'(exp), 21'(eff));
    endtask : neg
    task automatic t_nop;
        p = pc;
        issue(OPC_ZERO_WORD);
        issue(16'hF5A3);
        idle(1);
        chk("pc", p + 21'h4, pc);
        chk("flags", 21'h0, 21'(flags));
    endtask : t_nop
    task automatic t_addr;
        bank_select_register = 4'hA;
        bload = 1'b1;
        @(negedge clk);
        bload = 1'b0;
        neg(1'b1, 8'h42, 12'hA42);
        neg(1'b0, 8'h5F, 12'h05F);
        neg(1'b0, 8'h60, 12'hF60);
        ext = 1'b1;
        base = 12'h7F0;
        neg(1'b0, 8'h5F, 12'h84F);
        neg(1'b0, 8'h60, 12'hF60);
        neg(1'b1, 8'h10, 12'hA10);
        base = 12'hFF0;
        neg(1'b0, 8'h20, 12'h010);
    endtask : t_addr
    task automatic t_branch;
        issue({OPC_BRANCH_W1, 8'hDE});
        chk("busy", 21'h1, 21'(busy));
        issue({OPC_BRANCH_W2, 12'hABC});
        chk("pc", {20'hABCDE, 1'b0}, pc);
        chk("ready", 21'h0, 21'(ready));
        idle(1);
        chk("ready", 21'h1, 21'(ready));
    endtask : t_branch
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        chk("pc", 21'h0, pc);
        t_nop;
        t_addr;
        t_branch;
        test_done;
    end
    initial begin
        #20000;
        failures++;
        test_done;
    end
endmodule : bod_decoder_tb
`default_nettype wire
